// >>> core/tlp_core.sv
/*
  test-mode datapath of one transceiver channel: loopback steering,
  incremental and pseudo-random generators and checkers, fixed patterns,
  sticky event status with enable, clear and one interrupt.
  assumes mode and polynomial are static configuration set by module parameters,
  logic, resets and power-down come from another clock domain.
*/
// Added by the designer: the address map and the plain strobed port.
//Behaviour
//RQ1 - pre-recovery loopback only in basic mode; rx also still to fabric
//RQ2 - pre-recovery loopback is a static parameter, no run-time pin
//RQ3 - in pre-recovery loopback tx is raw rx, other tx stages bypassed
//RQ4 - pcie reverse parallel loopback returns aligned rx words to serializer
//RQ5 - loopback input selects pcie loopback; rx data still to fabric
//RQ6 - incremental test uses 16-bit generator and checker at 16-bit width
//RQ7 - incremental count 00..ff looped internally and sent on tx
//RQ8 - incremental mode checks rx internally, fabric rx output held zero
//RQ9 - prbs generator feeds serializer, checker reads word aligner data
//RQ10 - four prbs polynomials 7, 8, 10, 23 chosen at configuration
//RQ11 - each prbs pairs with fixed width and alignment word
//RQ12 - prbs runs free, repeating after each maximal period
//RQ13 - high and low frequency patterns, no checker for either
//RQ14 - tx digital reset clears generator, rx digital reset the checker
//RQ15 - rx reset keeps results under power-down or analog reset cases; incremental mode keeps them under power-down only
//RQ16 - in prbs mode serial loopback may be enabled at run time
//RQ17 - serial loopback enable is active high, per channel
//RQ18 - checker flags error on mismatch after alignment, done after a run
//RQ19 - one mode per channel; normal traffic after resets
`timescale 1ns/1ns

module tlp_core
  import tlp_pkg::*;
#(
  parameter tlp_mode_e MODE = TLP_MODE_NORMAL,
  parameter tlp_poly_e POLY = TLP_PRBS7,
  parameter logic DOUBLE_WIDTH = 1'b0,
  parameter logic PRECDR_EN = 1'b0
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_digital_reset,
  input wire logic rx_digital_reset,
  input wire logic rx_analog_reset,
  input wire logic pll_power_down,
  input wire logic serial_loopback_en,
  input wire logic rx_detect_loopback,
  input wire logic [15:0] tx_fabric_data,
  input wire logic [15:0] rx_aligned_data,
  input wire logic rx_serial_in,
  input wire logic [1:0] reg_addr,
  input wire logic [1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [1:0] reg_rdata,
  output logic [15:0] tx_ser_data,
  output logic tx_serial_out,
  output logic tx_bypass_stages,
  output logic serial_loopback_active,
  output logic [15:0] rx_fabric_data,
  output logic [15:0] int_loop_data,
  output logic check_error,
  output logic check_done,
  output logic irq
);

  // register map: 0 status (ro), 1 clear (wo), 2 enable
  localparam logic [1:0] A_STAT = 2'h0;
  localparam logic [1:0] A_CLR = 2'h1;
  localparam logic [1:0] A_EN = 2'h2;

  typedef struct packed {
    logic [1:0] txr_s;
    logic [1:0] rxr_s;
    logic [1:0] ana_s;
    logic [1:0] pll_s;
    logic [1:0] slb_s;
    logic [1:0] lpb_s;
    tlp_word_t gen;
    logic [22:0] lfsr;
    logic [3:0] lf_cnt;
    logic lf_lvl;
    tlp_ck_e ck;
    tlp_word_t expect_w;
    logic [22:0] ck_lfsr;
    logic [2:0] good;
    logic [7:0] words;
    logic err;
    logic done;
    logic [1:0] stat;
    logic [1:0] en;
    logic [1:0] rdata;
    tlp_word_t ser;
    logic ser_bit;
    logic bypass;
    logic slb;
    tlp_word_t rx_fab;
    tlp_word_t loop_w;
    logic irq;
  } tlp_state_s;

  tlp_state_s st_reg;
  tlp_state_s st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [22:0] prbs_step(input logic [22:0] s);
    logic fb;
    fb = 1'b0;
    unique case (POLY) // RQ10
      TLP_PRBS7: fb = s[6] ^ s[5];
      TLP_PRBS8: fb = s[7] ^ s[6];
      TLP_PRBS10: fb = s[9] ^ s[6];
      TLP_PRBS23: fb = s[22] ^ s[17];
    endcase
    return {s[21:0], fb}; // RQ12
  endfunction : prbs_step

  // advance one channel word of prbs bits
  function automatic logic [22:0] prbs_word(input logic [22:0] s);
    logic [22:0] t;
    t = s;
    for (int i = 0; i < 10; i++)
    begin
      if (i < 8 || POLY == TLP_PRBS10) // RQ11
      begin
        t = prbs_step(t);
      end
    end
    return t;
  endfunction : prbs_word

  function automatic tlp_word_t prbs_out(input logic [22:0] s);
    return (POLY == TLP_PRBS10) ? {6'h00, s[9:0]} : {8'h00, s[7:0]};
  endfunction : prbs_out

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic tx_rst;
    logic rx_rst;
    logic hold_res;
    logic is_chk;
    logic [3:0] lf_run;
    tlp_word_t rx_w;
    logic [1:0] ev;
    tx_rst = 1'b0;
    rx_rst = 1'b0;
    hold_res = 1'b0;
    is_chk = 1'b0;
    lf_run = 4'h0;
    rx_w = '0;
    ev = 2'h0;
    st_next = st_reg;

    // two-stage synchronisers for the asynchronous controls
    st_next.txr_s = {st_reg.txr_s[0], tx_digital_reset};
    st_next.rxr_s = {st_reg.rxr_s[0], rx_digital_reset};
    st_next.ana_s = {st_reg.ana_s[0], rx_analog_reset};
    st_next.pll_s = {st_reg.pll_s[0], pll_power_down};
    st_next.slb_s = {st_reg.slb_s[0], serial_loopback_en};
    st_next.lpb_s = {st_reg.lpb_s[0], rx_detect_loopback};
    tx_rst = st_reg.txr_s[1];
    rx_rst = st_reg.rxr_s[1];

    // results survive rx reset while the link is powered down
    if (MODE == TLP_MODE_INCR)
    begin
      hold_res = st_reg.pll_s[1]; // RQ15
    end
    else if (MODE == TLP_MODE_PRBS)
    begin
      hold_res = st_reg.pll_s[1] | st_reg.ana_s[1]; // RQ15
    end

    // -------------------- generators --------------------
    if (tx_rst)
    begin
      st_next.gen = '0; // RQ14
      st_next.lfsr = `TLP_SEED; // RQ14
      st_next.lf_cnt = 4'h0;
      st_next.lf_lvl = 1'b1;
    end
    else
    begin
      // low byte counts 00..ff, high byte carries the next count
      st_next.gen[7:0] = st_reg.gen[7:0] + 8'h01; // RQ6 RQ7
      st_next.gen[15:8] = st_reg.gen[7:0] + 8'h02; // RQ6
      st_next.lfsr = prbs_word(st_reg.lfsr); // RQ12
      lf_run = DOUBLE_WIDTH ? `TLP_LF_DOUBLE : `TLP_LF_SINGLE; // RQ13
      if (st_reg.lf_cnt == lf_run - 4'h1)
      begin
        st_next.lf_cnt = 4'h0;
        st_next.lf_lvl = ~st_reg.lf_lvl;
      end
      else
      begin
        st_next.lf_cnt = st_reg.lf_cnt + 4'h1;
      end
    end

    // -------------------- tx steering --------------------
    st_next.bypass = 1'b0;
    st_next.ser_bit = 1'b0;
    st_next.loop_w = '0;
    unique case (MODE) // RQ19
      TLP_MODE_PRECDR:
      begin
        st_next.ser = '0;
        st_next.bypass = PRECDR_EN; // RQ2 RQ3
        st_next.ser_bit = PRECDR_EN ? rx_serial_in : 1'b0; // RQ1 RQ3
      end
      TLP_MODE_PCIE:
      begin
        st_next.ser = st_reg.lpb_s[1] ? rx_aligned_data // RQ4 RQ5
                                      : tx_fabric_data;
      end
      TLP_MODE_INCR:
      begin
        st_next.ser = st_reg.gen; // RQ7
        st_next.loop_w = st_reg.gen; // RQ7
      end
      TLP_MODE_PRBS:
      begin
        st_next.ser = prbs_out(st_reg.lfsr); // RQ9
      end
      TLP_MODE_HFREQ:
      begin
        st_next.ser = 16'h5555; // RQ13
      end
      TLP_MODE_LFREQ:
      begin
        st_next.ser = {16{st_reg.lf_lvl}}; // RQ13
      end
      default:
      begin
        st_next.ser = tx_fabric_data;
      end
    endcase
    st_next.slb = (MODE == TLP_MODE_PRBS) & st_reg.slb_s[1]; // RQ16 RQ17

    // -------------------- rx to fabric --------------------
    if (MODE == TLP_MODE_INCR || MODE == TLP_MODE_PRBS)
    begin
      st_next.rx_fab = '0; // RQ8
    end
    else
    begin
      st_next.rx_fab = rx_aligned_data; // RQ1 RQ5
    end

    // -------------------- checker --------------------
    is_chk = (MODE == TLP_MODE_INCR) || (MODE == TLP_MODE_PRBS); // RQ13
    rx_w = (MODE == TLP_MODE_INCR) ? st_reg.loop_w // RQ7
                                   : rx_aligned_data; // RQ9
    if (rx_rst || !is_chk)
    begin
      st_next.ck = TLP_CK_IDLE; // RQ14
      st_next.good = 3'h0;
      st_next.words = 8'h00;
      if (!hold_res)
      begin
        st_next.err = 1'b0; // RQ14 RQ15
        st_next.done = 1'b0;
      end
    end
    else
    begin
      unique case (st_reg.ck)
        TLP_CK_IDLE:
        begin
          st_next.ck = TLP_CK_HUNT;
        end
        TLP_CK_HUNT:
        begin
          // seed from the received bits: after four words the state
          // holds every bit that the feedback taps can reach
          st_next.expect_w = rx_w;
          if (POLY == TLP_PRBS10) // RQ11
          begin
            st_next.ck_lfsr = {st_reg.ck_lfsr[12:0], rx_w[9:0]};
          end
          else
          begin
            st_next.ck_lfsr = {st_reg.ck_lfsr[14:0], rx_w[7:0]};
          end
          st_next.good = st_reg.good + 3'h1;
          if (st_reg.good == `TLP_ALIGN_GOOD)
          begin
            st_next.ck = TLP_CK_RUN;
          end
        end
        TLP_CK_RUN:
        begin
          if (MODE == TLP_MODE_INCR)
          begin
            st_next.expect_w = {st_reg.expect_w[7:0] + 8'h02,
                                st_reg.expect_w[7:0] + 8'h01};
            if (rx_w != st_next.expect_w)
            begin
              st_next.err = 1'b1; // RQ18
            end
          end
          else
          begin
            st_next.ck_lfsr = prbs_word(st_reg.ck_lfsr);
            if (rx_w != prbs_out(st_next.ck_lfsr))
            begin
              st_next.err = 1'b1; // RQ18
            end
          end
          st_next.words = st_reg.words + 8'h01;
          if (st_reg.words == `TLP_DONE_WORDS)
          begin
            st_next.done = 1'b1; // RQ18
          end
        end
        default:
        begin
          st_next.ck = TLP_CK_IDLE;
        end
      endcase
    end

    // -------------------- registers and interrupt --------------------
    ev[`TLP_EV_ERR] = st_next.err & ~st_reg.err;
    ev[`TLP_EV_DONE] = st_next.done & ~st_reg.done;
    // a new event beats a clear in the same cycle
    if (reg_wr && reg_addr == A_CLR)
    begin
      st_next.stat = (st_reg.stat & ~reg_wdata) | ev;
    end
    else
    begin
      st_next.stat = st_reg.stat | ev;
    end
    if (reg_wr && reg_addr == A_EN)
    begin
      st_next.en = reg_wdata;
    end
    st_next.rdata = 2'h0;
    if (reg_rd)
    begin
      if (reg_addr == A_STAT)
      begin
        st_next.rdata = st_reg.stat;
      end
      else if (reg_addr == A_EN)
      begin
        st_next.rdata = st_reg.en;
      end
    end
    st_next.irq = |(st_next.stat & st_next.en);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '{ck: TLP_CK_IDLE, lfsr: `TLP_SEED, lf_lvl: 1'b1,
                  ck_lfsr: `TLP_SEED, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign tx_ser_data = st_reg.ser;
  assign tx_serial_out = st_reg.ser_bit;
  assign tx_bypass_stages = st_reg.bypass;
  assign serial_loopback_active = st_reg.slb;
  assign rx_fabric_data = st_reg.rx_fab;
  assign int_loop_data = st_reg.loop_w;
  assign check_error = st_reg.err;
  assign check_done = st_reg.done;
  assign irq = st_reg.irq;

endmodule : tlp_core

// >>> core/tlp_params.svh
/*
  constants for the transceiver test-mode block: pattern widths, seeds,
  alignment words and interrupt bit positions.
  assumes inclusion from the package and the core module only.
*/
`ifndef TLP_PARAMS_SVH
`define TLP_PARAMS_SVH

`define TLP_WORD_W 16
`define TLP_INC_LAST 8'hff
`define TLP_ALIGN_P7 16'h3040
`define TLP_ALIGN_P8 16'hff5a
`define TLP_ALIGN_P10 16'h03ff
`define TLP_ALIGN_P23 16'hffff
`define TLP_SEED 23'h7fffff
`define TLP_LF_SINGLE 4'h5
`define TLP_LF_DOUBLE 4'ha
`define TLP_ALIGN_GOOD 3'h3
`define TLP_DONE_WORDS 8'hff
`define TLP_EV_ERR 0
`define TLP_EV_DONE 1
`define TLP_EV_W 2

`endif

// >>> core/tlp_pkg.sv
/*
  types for the transceiver test-mode block.
  assumes tlp_params.svh sits beside it.
*/
`include "tlp_params.svh"

package tlp_pkg;

  typedef enum logic [2:0] {
    TLP_MODE_NORMAL,
    TLP_MODE_PRECDR,
    TLP_MODE_PCIE,
    TLP_MODE_INCR,
    TLP_MODE_PRBS,
    TLP_MODE_HFREQ,
    TLP_MODE_LFREQ
  } tlp_mode_e;

  typedef enum logic [1:0] {
    TLP_PRBS7,
    TLP_PRBS8,
    TLP_PRBS10,
    TLP_PRBS23
  } tlp_poly_e;

  typedef enum logic [1:0] {
    TLP_CK_IDLE,
    TLP_CK_HUNT,
    TLP_CK_RUN
  } tlp_ck_e;

  typedef logic [`TLP_WORD_W-1:0] tlp_word_t;

endpackage : tlp_pkg

// >>> verif/tlp_core_chk.sv
/*
  port checks of the test-mode block in its pseudo-random setup.
  assumes a bind onto tlp_core, one clock, async active-low reset.
*/
`timescale 1ns/1ns

module tlp_core_chk
  import tlp_pkg::*;
#(
  parameter tlp_mode_e MODE = TLP_MODE_PRBS
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_digital_reset,
  input wire logic rx_analog_reset,
  input wire logic pll_power_down,
  input wire logic serial_loopback_en,
  input wire logic [1:0] reg_addr,
  input wire logic [1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_rdata,
  input wire logic tx_bypass_stages,
  input wire logic serial_loopback_active,
  input wire logic [15:0] rx_fabric_data,
  input wire logic check_error,
  input wire logic check_done,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic prbs;
  assign prbs = (MODE == TLP_MODE_PRBS);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_rx_quiet: assert property (
    !prbs || rx_fabric_data == 16'h0000)
    else $error("fabric rx data not quiet");
  chk_no_bypass: assert property (
    !prbs || !tx_bypass_stages)
    else $error("tx stages bypassed");
  // sync chain plus output register: five steady cycles is enough
  chk_loop_follow: assert property (
    (prbs && $stable(serial_loopback_en))[*5]
    |-> serial_loopback_active == serial_loopback_en)
    else $error("loopback state not following enable");
  chk_rx_clear: assert property (
    (rx_digital_reset && !pll_power_down && !rx_analog_reset)[*5]
    |-> !check_error && !check_done)
    else $error("checker results survive rx reset");
  chk_rx_hold: assert property (
    (prbs && (pll_power_down || rx_analog_reset))[*5] ##0 check_error
    |=> check_error)
    else $error("error flag lost while held");
  chk_err_sticky: assert property (
    (!rx_digital_reset)[*4] ##0 check_error |=> check_error)
    else $error("error flag dropped without reset");
  chk_irq_mask: assert property (
    reg_wr && reg_addr == 2'h2 && reg_wdata == 2'h0 |-> ##2 !irq)
    else $error("interrupt up with all enables off");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 2'h0)
    else $error("read data outside read slot");
  chk_rd_blank: assert property (
    reg_rd && reg_addr[0] |=> reg_rdata == 2'h0)
    else $error("clear or unmapped place reads nonzero");
endmodule : tlp_core_chk

bind tlp_core tlp_core_chk #(.MODE(MODE)) u_chk (
  .clk, .rst_n, .rx_digital_reset, .rx_analog_reset, .pll_power_down,
  .serial_loopback_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tx_bypass_stages, .serial_loopback_active,
  .rx_fabric_data, .check_error, .check_done, .irq
);

// >>> verif/tlp_far_end.sv
/*
  far end: a bit error tester that returns each transmitted word to
  the word aligner, with a single-bit error on command.
  assumes the block's clock and reset.
*/
`timescale 1ns/1ns

module tlp_far_end (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] tx_ser_data,
  input wire logic flip,
  output logic [15:0] rx_aligned_data,
  output logic rx_serial_in
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_aligned_data <= 16'h0000;
      rx_serial_in <= 1'b0;
    end
    else
    begin
      rx_aligned_data <= tx_ser_data ^ {15'h0000, flip};
      // unused raw line toggles so no stale level can pass for data
      rx_serial_in <= !rx_serial_in;
    end
  end
endmodule : tlp_far_end

// >>> verif/tb_top.sv
/*
  self-checking bench of the test-mode block, pseudo-random setup.
  assumes the far-end model and the port checker beside it.
*/
`timescale 1ns/1ns

module tb_top
  import tlp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_digital_reset = 1'b0;
  logic rx_digital_reset = 1'b0;
  logic rx_analog_reset = 1'b0;
  logic pll_power_down = 1'b0;
  logic serial_loopback_en = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [1:0] reg_wdata = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic flip = 1'b0;
  logic [1:0] reg_rdata;
  logic [15:0] tx_ser_data, rx_aligned_data, rx_fabric_data;
  logic rx_serial_in, tx_bypass_stages, serial_loopback_active;
  logic check_error, check_done, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  // packing: wr, rd, addr[1:0], wdata[1:0], expected rdata[1:0]
  logic [7:0] rows [0:9] = '{8'hac, 8'h63, 8'h50, 8'h70, 8'hbc,
                             8'h70, 8'h40, 8'h8c, 8'h40, 8'h63};

  tlp_core #(.MODE(TLP_MODE_PRBS), .POLY(TLP_PRBS7)) uut (
    .clk, .rst_n, .tx_digital_reset, .rx_digital_reset,
    .rx_analog_reset, .pll_power_down, .serial_loopback_en,
    .rx_detect_loopback(1'b0), .tx_fabric_data(16'h0000),
    .rx_aligned_data, .rx_serial_in, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_ser_data, .tx_serial_out(),
    .tx_bypass_stages, .serial_loopback_active, .rx_fabric_data,
    .int_loop_data(), .check_error, .check_done, .irq
  );

  tlp_far_end u_far (
    .clk, .rst_n, .tx_ser_data, .flip, .rx_aligned_data, .rx_serial_in
  );

  initial
    forever #5 clk = ~clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  // strobes stand one cycle; read data checked in the cycle after
  task automatic reg_op(input logic w, r, input logic [1:0] a, d, e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (r)
    begin
      @(negedge clk);
      cmp_val(16'(reg_rdata), 16'(e));
    end
  endtask : reg_op

  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++)
      @(negedge clk);
    cmp_val(16'(s), 16'(v));
  endtask : wait_for

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    cmp_val({12'h000, irq, check_error, check_done,
             serial_loopback_active}, 16'h0000);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
      reg_op(rows[i][7], rows[i][6], rows[i][5:4], rows[i][3:2],
             rows[i][1:0]);
    wait_for(check_done, 1'b1, 1000);
    cmp_val(16'(check_error), 16'h0000);
    cmp_val(rx_fabric_data, 16'h0000);
    cmp_val(16'(tx_bypass_stages), 16'h0000);
    reg_op(1'b0, 1'b1, 2'h0, 2'h0, 2'h2);
    wait_for(irq, 1'b1, 4);
    @(posedge clk);
    serial_loopback_en <= 1'b1;
    wait_for(serial_loopback_active, 1'b1, 8);
    cmp_val(16'(check_error), 16'h0000);
    @(posedge clk);
    serial_loopback_en <= 1'b0;
    wait_for(serial_loopback_active, 1'b0, 8);
    @(posedge clk);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    wait_for(check_error, 1'b1, 50);
    reg_op(1'b0, 1'b1, 2'h0, 2'h0, 2'h3);
    reg_op(1'b1, 1'b0, 2'h2, 2'h0, 2'h0);
    reg_op(1'b0, 1'b0, 2'h0, 2'h0, 2'h0);
    wait_for(irq, 1'b0, 3);
    // clear both, then unmask only the error bit: no new error comes
    reg_op(1'b1, 1'b0, 2'h1, 2'h3, 2'h0);
    reg_op(1'b1, 1'b0, 2'h2, 2'h1, 2'h0);
    reg_op(1'b0, 1'b0, 2'h0, 2'h0, 2'h0);
    repeat (3) @(negedge clk);
    cmp_val(16'(irq), 16'h0000);
    for (int h = 0; h < 3; h++)
    begin
      @(posedge clk);
      pll_power_down <= (h == 0);
      rx_analog_reset <= (h == 1);
      repeat (5) @(posedge clk);
      rx_digital_reset <= 1'b1;
      repeat (10) @(negedge clk);
      cmp_val(16'(check_error), 16'(h != 2));
      cmp_val(16'(check_done), 16'(h != 2));
      @(posedge clk);
      rx_digital_reset <= 1'b0;
    end
    wait_for(check_done, 1'b1, 1000);
    cmp_val(16'(check_error), 16'h0000);
    // generator parked on its all-ones seed while tx reset stands
    @(posedge clk);
    tx_digital_reset <= 1'b1;
    repeat (6) @(negedge clk);
    cmp_val(tx_ser_data, 16'h00ff);
    close_out();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
